/* File: intc_pkg.sv */
// Register map, field positions and encodings for the interrupt controller
package intc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_REQ = 6;
  // Register offsets
  localparam logic [7:0] OFF_PRIORITY = 8'h09;
  localparam logic [7:0] OFF_MASK = 8'h0b;
  localparam logic [7:0] OFF_SUPPLY = 8'h0c;
  localparam logic [7:0] OFF_REQUEST = 8'h0a;
  // Mask register fields
  localparam int MASK_MASTER = 7;
  localparam int MASK_RSVD = 6;
  // Supply monitor fields
  localparam int SUP_ON = 0;
  localparam int SUP_LOW = 1;
  localparam int SUP_PAD = 2;
  localparam logic [7:0] SUP_RSVD_READ = 8'hf8;
  // Priority register fields
  localparam int PRI_A = 5;
  localparam int PRI_B = 2;
  localparam int PRI_C = 1;
  localparam int PRI_G2 = 4;
  localparam int PRI_G1 = 3;
  localparam int PRI_G0 = 0;
  // Group order codes
  localparam logic [2:0] ORD_CAB = 3'h1;
  localparam logic [2:0] ORD_ABC = 3'h2;
  localparam logic [2:0] ORD_ACB = 3'h3;
  localparam logic [2:0] ORD_BCA = 3'h4;
  localparam logic [2:0] ORD_CBA = 3'h5;
  localparam logic [2:0] ORD_BAC = 3'h6;
  // Request indices
  localparam int RQ_TIMER1 = 5;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [5:0] ZERO6 = 6'h00;
endpackage

/* File: intc_prio_pick.sv */
// Combinational priority resolver over the six pending requests
`timescale 1ns/10ps
`default_nettype none
module intc_prio_pick (
  // Inputs
  input wire logic [5:0] active,
  input wire logic [7:0] prio,
  // Result
  output logic found,
  output logic [2:0] index
);
  import intc_pkg::*;

  logic [2:0] win_a, win_b, win_c, g1, g2, g3;
  logic has_a, has_b, has_c;

  // Winner inside each pair
  always_comb begin
    win_a = prio[PRI_A] ? 3'h3 : 3'h5;
    if (prio[PRI_A] ? !active[3] : !active[5])
      win_a = prio[PRI_A] ? 3'h5 : 3'h3;
    win_b = prio[PRI_B] ? 3'h0 : 3'h2;
    if (prio[PRI_B] ? !active[0] : !active[2])
      win_b = prio[PRI_B] ? 3'h2 : 3'h0;
    win_c = prio[PRI_C] ? 3'h4 : 3'h1;
    if (prio[PRI_C] ? !active[4] : !active[1])
      win_c = prio[PRI_C] ? 3'h1 : 3'h4;
    has_a = active[3] | active[5];
    has_b = active[0] | active[2];
    has_c = active[1] | active[4];
  end

  // Group order, reserved codes select nothing
  always_comb begin
    found = 1'b0;
    index = 3'h0;
    g1 = 3'h0;
    g2 = 3'h0;
    g3 = 3'h0;
    case ({prio[PRI_G2], prio[PRI_G1], prio[PRI_G0]})
      ORD_CAB: begin g1 = 3'h2; g2 = 3'h0; g3 = 3'h1; end
      ORD_ABC: begin g1 = 3'h0; g2 = 3'h1; g3 = 3'h2; end
      ORD_ACB: begin g1 = 3'h0; g2 = 3'h2; g3 = 3'h1; end
      ORD_BCA: begin g1 = 3'h1; g2 = 3'h2; g3 = 3'h0; end
      ORD_CBA: begin g1 = 3'h2; g2 = 3'h1; g3 = 3'h0; end
      ORD_BAC: begin g1 = 3'h1; g2 = 3'h0; g3 = 3'h2; end
      default: begin g1 = 3'h7; g2 = 3'h7; g3 = 3'h7; end
    endcase
    for (int k = 0; k < 3; k++) begin
      logic [2:0] g;
      g = (k == 0) ? g3 : ((k == 1) ? g2 : g1);
      if (g == 3'h0 && has_a) begin found = 1'b1; index = win_a; end
      if (g == 3'h1 && has_b) begin found = 1'b1; index = win_b; end
      if (g == 3'h2 && has_c) begin found = 1'b1; index = win_c; end
    end
  end
endmodule
`default_nettype wire

/* File: intc_top.sv */
// Interrupt mask, priority and request logic with supply monitor flags
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Low supply sets readable status flag
// - Supply bit 1 shows low flag, read-only
// - Bit 2 pad status; write clears it
// - Bit 0 enables monitor, owns request 5
// - Six requests, each maskable and prioritised
// - Master bit 7 gates all recognition
// - Mask bits 5..0 enable requests; reset zero
// - Service clears master; return sets it
// - Priority register write-only, reset zero
// - Three request pairs A, B, C
// - Bits 5,2,1 order within pairs
// - Bits 4,3,0 order the groups
// - Priority bits 7,6 ignored
// - Source request sets its request bit
// - Request bits locked until first enable
module intc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [intc_pkg::ADDR_W-1:0] addr,
  input wire logic [intc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [intc_pkg::DATA_W-1:0] rdata,
  // Core instruction events
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic interrupt_return_instr,
  input wire logic service_ack,
  // Request sources
  input wire logic [5:0] source_req,
  input wire logic timer1_req,
  input wire logic low_voltage_pin,
  input wire logic pad_unregulated_pin,
  // Vector to core
  output logic vector_valid,
  output logic [2:0] vector_index
);
  import intc_pkg::*;

  logic [7:0] mask_q, mask_d;
  logic [7:0] prio_q, prio_d;
  logic [5:0] request_q, request_d;
  logic unlocked_q, unlocked_d;
  logic mon_on_q, mon_on_d;
  logic low_q, low_d;
  logic pad_q, pad_d;
  logic [7:0] rdata_q, rdata_d;
  logic vvalid_q, vvalid_d;
  logic [2:0] vindex_q, vindex_d;
  logic [1:0] lv_sync_q, pad_sync_q;
  logic [5:0] src_eff, enabled;
  logic found;
  logic [2:0] pick;

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lv_sync_q <= 2'h0;
      pad_sync_q <= 2'h0;
    end else begin
      lv_sync_q <= {lv_sync_q[0], low_voltage_pin};
      pad_sync_q <= {pad_sync_q[0], pad_unregulated_pin};
    end
  end

  // Source routing, request 5 owned by monitor when on
  always_comb begin
    src_eff = source_req;
    src_eff[RQ_TIMER1] = mon_on_q ? low_q : (source_req[RQ_TIMER1] |
                                             timer1_req);
    enabled = request_q & mask_q[5:0];
  end

  intc_prio_pick u_pick (
    .active(enabled),
    .prio(prio_q),
    .found(found),
    .index(pick)
  );

  // Next state of all registers except the pin synchronisers
  always_comb begin
    mask_d = mask_q;
    prio_d = prio_q;
    request_d = request_q;
    unlocked_d = unlocked_q;
    mon_on_d = mon_on_q;
    low_d = low_q;
    pad_d = pad_q;
    rdata_d = ZERO8;
    vvalid_d = 1'b0;
    vindex_d = vindex_q;
    // Software writes
    if (wr) begin
      case (addr)
        OFF_MASK: mask_d = {mask_q[MASK_MASTER], 1'b0, wdata[5:0]};
        OFF_PRIORITY: prio_d = {2'h0, wdata[5:0]};
        OFF_SUPPLY: begin
          mon_on_d = wdata[SUP_ON];
          pad_d = 1'b0;
        end
        OFF_REQUEST: if (unlocked_q) request_d = wdata[5:0];
        default: ;
      endcase
    end
    // Supply monitor flags, set wins over clear
    low_d = mon_on_q & lv_sync_q[1];
    if (pad_sync_q[1]) pad_d = 1'b1;
    // Instruction effects on master enable
    if (enable_interrupts_instr) begin
      mask_d[MASK_MASTER] = 1'b1;
      unlocked_d = 1'b1;
    end
    if (disable_interrupts_instr) mask_d[MASK_MASTER] = 1'b0;
    if (interrupt_return_instr) mask_d[MASK_MASTER] = 1'b1;
    // Service entry clears master and the serviced bit
    if (service_ack && vvalid_q) begin
      mask_d[MASK_MASTER] = 1'b0;
      request_d[vindex_q] = 1'b0;
    end
    // Source requests set bits once unlocked
    if (unlocked_q) request_d = request_d | src_eff;
    // Vector selection
    if (mask_q[MASK_MASTER] && found && !(service_ack && vvalid_q)) begin
      vvalid_d = 1'b1;
      vindex_d = pick;
    end
    // Read data
    if (rd) begin
      case (addr)
        OFF_MASK: rdata_d = mask_q | (8'h01 << MASK_RSVD);
        OFF_SUPPLY: rdata_d = SUP_RSVD_READ | {5'h00, pad_q, low_q, mon_on_q};
        OFF_REQUEST: rdata_d = {2'h0, request_q};
        default: rdata_d = ZERO8;
      endcase
    end
  end

  // State registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= ZERO8;
      prio_q <= ZERO8;
      request_q <= ZERO6;
      unlocked_q <= 1'b0;
      mon_on_q <= 1'b0;
      low_q <= 1'b0;
      pad_q <= 1'b0;
      rdata_q <= ZERO8;
      vvalid_q <= 1'b0;
      vindex_q <= 3'h0;
    end else begin
      mask_q <= mask_d;
      prio_q <= prio_d;
      request_q <= request_d;
      unlocked_q <= unlocked_d;
      mon_on_q <= mon_on_d;
      low_q <= low_d;
      pad_q <= pad_d;
      rdata_q <= rdata_d;
      vvalid_q <= vvalid_d;
      vindex_q <= vindex_d;
    end
  end

  assign rdata = rdata_q;
  assign vector_valid = vvalid_q;
  assign vector_index = vindex_q;

  // Checks
  AST_MASTER_GATE: assert property (@(posedge clk) disable iff (rst)
    vector_valid |-> $past(mask_q[MASK_MASTER]))
    else $error("vector raised with master off");
  AST_LOCKED: assert property (@(posedge clk) disable iff (rst)
    !unlocked_q |-> request_q == ZERO6)
    else $error("request bits set before enable");
  AST_SERVICE_CLR: assert property (@(posedge clk) disable iff (rst)
    (service_ack && vector_valid && !interrupt_return_instr &&
     !enable_interrupts_instr) |=> !mask_q[MASK_MASTER])
    else $error("master not cleared on service");
  AST_RETURN_SET: assert property (@(posedge clk) disable iff (rst)
    (interrupt_return_instr && !service_ack && !disable_interrupts_instr)
    |=> mask_q[MASK_MASTER])
    else $error("master not set by return");
  AST_PRIO_RSVD: assert property (@(posedge clk) disable iff (rst)
    prio_q[7:6] == 2'h0)
    else $error("reserved priority bits stored");
  AST_LOW_FLAG: assert property (@(posedge clk) disable iff (rst)
    !mon_on_q |=> !low_q)
    else $error("low flag set with monitor off");
  AST_PAD_CLR: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == OFF_SUPPLY && !pad_sync_q[1]) |=> !pad_q)
    else $error("pad flag not cleared by write");
  AST_VEC_EN: assert property (@(posedge clk) disable iff (rst)
    vector_valid |-> $past(enabled[pick]))
    else $error("vector to disabled request");

  // Register port checks
  AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == ZERO8)
    else $error("read data not zero outside a read");
  AST_PRIO_WO: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFF_PRIORITY) |=> rdata == ZERO8)
    else $error("priority register read back");
  AST_PRIO_WR: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == OFF_PRIORITY) |=>
    prio_q[NUM_REQ-1:0] == $past(wdata[NUM_REQ-1:0]))
    else $error("priority write not stored");
  AST_MASK_WR: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == OFF_MASK) |=>
    mask_q[NUM_REQ-1:0] == $past(wdata[NUM_REQ-1:0]))
    else $error("mask enables not stored");
  AST_MASK_RSVD_RD: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFF_MASK) |=> rdata[MASK_RSVD])
    else $error("mask reserved bit not read as one");
  AST_SUP_RSVD_RD: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFF_SUPPLY) |=>
    (rdata & SUP_RSVD_READ) == SUP_RSVD_READ)
    else $error("supply reserved bits not read as ones");
  AST_LOW_RD: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFF_SUPPLY) |=> rdata[SUP_LOW] == $past(low_q))
    else $error("low flag not shown on read");
  AST_PAD_RD: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFF_SUPPLY) |=> rdata[SUP_PAD] == $past(pad_q))
    else $error("pad flag not shown on read");

  // Master enable and request unlock checks
  AST_MASTER_WR: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == OFF_MASK && !enable_interrupts_instr &&
     !disable_interrupts_instr && !interrupt_return_instr &&
     !(service_ack && vector_valid)) |=> $stable(mask_q[MASK_MASTER]))
    else $error("master bit changed by register write");
  AST_DI_CLR: assert property (@(posedge clk) disable iff (rst)
    (disable_interrupts_instr && !interrupt_return_instr) |=>
    !mask_q[MASK_MASTER])
    else $error("master not cleared by disable");
  AST_EI_SET: assert property (@(posedge clk) disable iff (rst)
    (enable_interrupts_instr && !disable_interrupts_instr &&
     !(service_ack && vector_valid)) |=> mask_q[MASK_MASTER])
    else $error("master not set by enable");
  AST_UNLOCK: assert property (@(posedge clk) disable iff (rst)
    enable_interrupts_instr |=> unlocked_q)
    else $error("request register not unlocked by enable");

  // Supply monitor checks
  AST_MON_WR: assert property (@(posedge clk) disable iff (rst)
    (wr && addr == OFF_SUPPLY) |=> mon_on_q == $past(wdata[SUP_ON]))
    else $error("monitor enable not stored");
  AST_LOW_SET: assert property (@(posedge clk) disable iff (rst)
    (mon_on_q && lv_sync_q[1]) |=> low_q)
    else $error("low flag not set by low supply");
  AST_PAD_SET: assert property (@(posedge clk) disable iff (rst)
    pad_sync_q[1] |=> pad_q)
    else $error("pad flag not set by unregulated pad");
  AST_REQ5_OWN: assert property (@(posedge clk) disable iff (rst)
    (mon_on_q && unlocked_q && low_q) |=> request_q[RQ_TIMER1])
    else $error("low supply did not raise request 5");
  AST_T1_BLOCK: assert property (@(posedge clk) disable iff (rst)
    (mon_on_q && !low_q && !request_q[RQ_TIMER1] &&
     !(wr && addr == OFF_REQUEST)) |=> !request_q[RQ_TIMER1])
    else $error("request 5 raised with monitor on");

  // Request and vector checks
  for (genvar k = 0; k < NUM_REQ; k++) begin : g_src
    AST_SRC_SET: assert property (@(posedge clk) disable iff (rst)
      (unlocked_q && src_eff[k]) |=> request_q[k])
      else $error("source request did not set its bit");
  end
  AST_REQ_CLR: assert property (@(posedge clk) disable iff (rst)
    (service_ack && vector_valid && !src_eff[vector_index]) |=>
    !request_q[$past(vector_index)])
    else $error("serviced request bit not cleared");
  AST_VEC_NEXT: assert property (@(posedge clk) disable iff (rst)
    (mask_q[MASK_MASTER] && found && !(service_ack && vector_valid))
    |=> vector_valid)
    else $error("pending enabled request not vectored");
  AST_NO_VEC: assert property (@(posedge clk) disable iff (rst)
    !found |=> !vector_valid)
    else $error("vector raised with nothing enabled");
  AST_VEC_DROP: assert property (@(posedge clk) disable iff (rst)
    (service_ack && vector_valid) |=> !vector_valid)
    else $error("vector held after service entry");
  AST_RSVD_GROUP: assert property (@(posedge clk) disable iff (rst)
    (prio_q[PRI_G2] == prio_q[PRI_G1] && prio_q[PRI_G1] == prio_q[PRI_G0])
    |-> !found)
    else $error("reserved group order selected a request");
  AST_PAIR_A: assert property (@(posedge clk) disable iff (rst)
    (found && enabled[3] && enabled[5] && (pick == 3'h3 || pick == 3'h5))
    |-> pick == (prio_q[PRI_A] ? 3'h3 : 3'h5))
    else $error("wrong member of pair A chosen");
  AST_PAIR_B: assert property (@(posedge clk) disable iff (rst)
    (found && enabled[0] && enabled[2] && (pick == 3'h0 || pick == 3'h2))
    |-> pick == (prio_q[PRI_B] ? 3'h0 : 3'h2))
    else $error("wrong member of pair B chosen");
  AST_PAIR_C: assert property (@(posedge clk) disable iff (rst)
    (found && enabled[1] && enabled[4] && (pick == 3'h1 || pick == 3'h4))
    |-> pick == (prio_q[PRI_C] ? 3'h4 : 3'h1))
    else $error("wrong member of pair C chosen");
endmodule
`default_nettype wire

/* File: intc_core_model.sv */
// Behavioural core model that acknowledges vectored requests
`timescale 1ns/10ps
`default_nettype none
module intc_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Vector from controller
  input wire logic vector_valid,
  input wire logic [2:0] vector_index,
  input wire logic ack_en,
  // Acknowledge to controller
  output logic service_ack,
  output logic [2:0] served_q
);
  logic ack_d;
  logic [2:0] served_d;
  // One acknowledge per vector; master bit is left to instructions
  always_comb begin
    ack_d = ack_en && vector_valid && !service_ack;
    served_d = ack_d ? vector_index : served_q;
  end
  // Register acknowledge and last served index
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      service_ack <= 1'h0;
      served_q <= 3'h0;
    end else begin
      service_ack <= ack_d;
      served_q <= served_d;
    end
  end
endmodule
`default_nettype wire

/* File: interrupt_mask_priority_lvd_tb_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module interrupt_mask_priority_lvd_tb_top;
  import intc_pkg::*;
  typedef struct {logic [7:0] p; logic [5:0] r; logic v; logic [2:0] i;} row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rv;
  logic wr = 1'h0, rd = 1'h0, ack_en = 1'h0, t1 = 1'h0, lv = 1'h0, pad = 1'h0;
  logic [2:0] ins = 3'h0;
  logic [5:0] src = 6'h00;
  logic vv, ack;
  logic [2:0] vi, served;
  int bad_count = 0, num_checks = 0;
  row_t rows [11] = '{'{8'h28, 6'h3f, 1'h1, 3'h3}, '{8'h01, 6'h3f, 1'h1, 3'h1},
    '{8'h03, 6'h3f, 1'h1, 3'h4}, '{8'h14, 6'h3f, 1'h1, 3'h0},
    '{8'h10, 6'h3f, 1'h1, 3'h2}, '{8'h09, 6'h3f, 1'h1, 3'h5},
    '{8'h11, 6'h2d, 1'h1, 3'h2}, '{8'h18, 6'h3a, 1'h1, 3'h5},
    '{8'h00, 6'h3f, 1'h0, 3'h0}, '{8'h19, 6'h3f, 1'h0, 3'h0},
    '{8'hc8, 6'h3f, 1'h1, 3'h5}};
  // Clock
  always #2.5 clk = ~clk;
  intc_top i_intc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .enable_interrupts_instr(ins[0]),
    .disable_interrupts_instr(ins[1]), .interrupt_return_instr(ins[2]),
    .service_ack(ack), .source_req(src), .timer1_req(t1),
    .low_voltage_pin(lv), .pad_unregulated_pin(pad),
    .vector_valid(vv), .vector_index(vi));
  intc_core_model i_intc_core_model (.clk(clk), .rst(rst),
    .vector_valid(vv), .vector_index(vi), .ack_en(ack_en),
    .service_ack(ack), .served_q(served));
  // Compare and count
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Wait n edges, then settle to the falling edge before looking
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // Register write, one strobe cycle
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  // Register read, data taken in the following cycle
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    rv = rdata;
  endtask
  // Instruction pulse: 0 enable, 1 disable, 2 return
  task automatic pulse(input int n);
    @(posedge clk);
    ins <= 3'h1 << n;
    @(posedge clk);
    ins <= 3'h0;
  endtask
  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    bad_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    rreg(OFF_MASK);
    check(rv, 8'h40);
    rreg(OFF_SUPPLY);
    check(rv, 8'hf8);
    rreg(OFF_PRIORITY);
    check(rv, 8'h00);
    wreg(OFF_REQUEST, 8'h3f);
    rreg(OFF_REQUEST);
    check(rv, 8'h00);
    wreg(OFF_MASK, 8'hbf);
    rreg(OFF_MASK);
    check(rv, 8'h7f);
    pulse(0);
    foreach (rows[k]) begin
      pulse(1);
      wreg(OFF_PRIORITY, rows[k].p);
      wreg(OFF_REQUEST, {2'h0, rows[k].r});
      pulse(0);
      wait_cyc(3);
      check({7'h0, vv}, {7'h0, rows[k].v});
      if (rows[k].v) check({5'h0, vi}, {5'h0, rows[k].i});
    end
    // Master off hides pending requests
    pulse(1);
    wait_cyc(2);
    check({7'h0, vv}, 8'h00);
    // Service entry and return
    ack_en <= 1'h1;
    pulse(0);
    wait_cyc(6);
    check({5'h0, served}, 8'h05);
    rreg(OFF_MASK);
    check(rv, 8'h7f);
    rreg(OFF_REQUEST);
    check(rv, 8'h1f);
    ack_en <= 1'h0;
    pulse(2);
    rreg(OFF_MASK);
    check(rv, 8'hff);
    check({5'h0, vi}, 8'h03);
    // Source request sets its bit
    pulse(1);
    wreg(OFF_REQUEST, 8'h00);
    @(posedge clk);
    src <= 6'h04;
    @(posedge clk);
    src <= 6'h00;
    rreg(OFF_REQUEST);
    check(rv, 8'h04);
    // Low supply flag and request 5 ownership
    wreg(OFF_SUPPLY, 8'h01);
    lv <= 1'h1;
    wait_cyc(4);
    rreg(OFF_SUPPLY);
    check(rv, 8'hfb);
    rreg(OFF_REQUEST);
    check(rv, 8'h24);
    lv <= 1'h0;
    wait_cyc(4);
    wreg(OFF_REQUEST, 8'h00);
    @(posedge clk);
    t1 <= 1'h1;
    @(posedge clk);
    t1 <= 1'h0;
    rreg(OFF_REQUEST);
    check(rv, 8'h00);
    // Pad flag: pin wins over clear, then write clears
    pad <= 1'h1;
    wait_cyc(4);
    wreg(OFF_SUPPLY, 8'h01);
    rreg(OFF_SUPPLY);
    check(rv, 8'hfd);
    pad <= 1'h0;
    wait_cyc(4);
    wreg(OFF_SUPPLY, 8'h01);
    rreg(OFF_SUPPLY);
    check(rv, 8'hf9);
    // Reset in mid-run returns registers and lock to reset state
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rreg(OFF_SUPPLY);
    check(rv, 8'hf8);
    rreg(OFF_MASK);
    check(rv, 8'h40);
    wreg(OFF_REQUEST, 8'h3f);
    rreg(OFF_REQUEST);
    check(rv, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
